// ===== sfesm_map.svh
/*
 holds the register offsets, field positions, reset values, live mask
 and safe-mode marker of the supply_fault_events block.
 assumes it is included by bare name wherever these values are needed.
*/
`ifndef SFESM_MAP_SVH
`define SFESM_MAP_SVH
`define SFESM_CMD_EVENTS_RO 8'h0A
`define SFESM_CMD_EVENTS_CR 8'h0B
`define SFESM_CMD_DISC_ONE 8'h0C
`define SFESM_CMD_DISC_TWO 8'h0D
`define SFESM_CMD_PRIO_MODE 8'h17
`define SFESM_CMD_PRIO_LOW 8'h27
`define SFESM_CMD_PRIO_HIGH 8'h28
`define SFESM_CMD_FW_REV 8'h41
`define SFESM_CMD_MEM_CTRL 8'h60
`define SFESM_BIT_THERMAL 7
`define SFESM_BIT_LOCKOUT 6
`define SFESM_BIT_WARNING 5
`define SFESM_BIT_PORT_LOW 4
`define SFESM_BIT_SHUTDOWN 1
`define SFESM_BIT_MEMFAULT 0
`define SFESM_BIT_PRIO_MODE 0
`define SFESM_BIT_RUN_EN 0
`define SFESM_BIT_PARITY_EN 1
`define SFESM_EVENTS_POR 8'h70
`define SFESM_EVENTS_LIVE_MASK 8'hF3
// safe-mode marker: the value is arbitrary
`define SFESM_SAFE_MARKER 8'hA5
`endif

// ===== sfesm_pkg.sv
/*
 holds the types of the supply_fault_events block.
 assumes the map header supplies the numbers.
*/
package sfesm_pkg;
   typedef enum logic [1:0] {
      SFESM_RUN = 2'b01,
      SFESM_SAFE = 2'b10
   } sfesm_mode_t;

   typedef struct packed {
      logic thermal_shutdown;
      logic thermal_cool;
      logic logic_supply_lockout;
      logic logic_supply_warning;
      logic port_supply_low;
      logic port_supply_ok;
      logic port_supply_dead;
      logic memory_error;
   } sfesm_cond_t;

   typedef struct packed {
      logic cmd_valid;
      logic cmd_write;
      logic [7:0] cmd_addr;
      logic [7:0] cmd_wdata;
   } sfesm_cmd_t;
endpackage

// ===== sfesm_block.sv
/*
 holds the supply_fault_events register, the memory-fault safe mode
 and the first two channel discovery bytes.
 assumes commands arrive decoded from the serial interface, one per cycle,
 and analog monitors arrive as synchronous levels.
*/
`timescale 1ns/1ps
`include "sfesm_map.svh"

module sfesm_block #(
   parameter int CHANNELS = 8
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire sfesm_pkg::sfesm_cmd_t cmd,
   input wire sfesm_pkg::sfesm_cond_t cond,
   input wire logic fast_shutdown_input,
   input wire logic [2:0] shutdown_code,
   input wire logic shutdown_code_valid,
   input wire logic [CHANNELS-1:0] fast_shutdown_enable,
   input wire logic [CHANNELS-1:0] channel_powered,
   input wire logic [CHANNELS-1:0] channel_power_on_command,
   input wire logic [7:0] channel_one_result,
   input wire logic [7:0] channel_two_result,
   input wire logic parity_image_loaded,
   input wire logic [7:0] firmware_revision,
   output logic [7:0] read_data,
   output logic read_valid,
   output logic event_irq,
   output logic [CHANNELS-1:0] channel_enable,
   output logic [CHANNELS-1:0] channel_force_off,
   output logic events_keep,
   output logic safe_mode
);
   // the group and shutdown logic is built for two groups of four
   if (CHANNELS != 8)
   begin : g_bad_channels
      $error("sfesm_block serves eight channels only");
   end

   // ------------------------------------------------------------
   // reset image and live mask
   // ------------------------------------------------------------
   localparam logic [7:0] EVENTS_POR = `SFESM_EVENTS_POR;
   localparam logic [7:0] LIVE_MASK = `SFESM_EVENTS_LIVE_MASK;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a);
      hit = cmd.cmd_valid && cmd.cmd_addr == a;
   endfunction

   logic wr;
   logic rd;
   assign wr = cmd.cmd_valid && cmd.cmd_write;
   assign rd = cmd.cmd_valid && !cmd.cmd_write;

   // ------------------------------------------------------------
   // host settings
   // ------------------------------------------------------------
   logic prio_mode;
   logic [23:0] prio_level;
   logic run_enable;
   logic parity_enable;
   logic [7:0] events;
   logic fault_hit;
   sfesm_pkg::sfesm_mode_t mode;

   // safe mode holds back ordinary settings, so reload path stays open
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         prio_mode <= 1'b0;
      else if (wr && mode == sfesm_pkg::SFESM_RUN &&
         hit(`SFESM_CMD_PRIO_MODE))
         prio_mode <= cmd.cmd_wdata[`SFESM_BIT_PRIO_MODE];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         prio_level <= 24'h000000;
      else if (wr && mode == sfesm_pkg::SFESM_RUN)
      begin
         if (cmd.cmd_addr == `SFESM_CMD_PRIO_LOW)
            prio_level[11:0] <= {cmd.cmd_wdata[6:4], cmd.cmd_wdata[6:4],
               cmd.cmd_wdata[2:0], cmd.cmd_wdata[2:0]};
         if (cmd.cmd_addr == `SFESM_CMD_PRIO_HIGH)
            prio_level[23:12] <= {cmd.cmd_wdata[6:4], cmd.cmd_wdata[6:4],
               cmd.cmd_wdata[2:0], cmd.cmd_wdata[2:0]};
      end
   end

   // memory fault monitor only armed by parity enable plus image
   // arming condition
   assign fault_hit = cond.memory_error && parity_enable &&
      parity_image_loaded;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         run_enable <= 1'b1;
      else if (fault_hit)
         run_enable <= 1'b0;
      else if (wr && hit(`SFESM_CMD_MEM_CTRL))
         run_enable <= cmd.cmd_wdata[`SFESM_BIT_RUN_EN];
   end

   // parity enable is a plain setting; a fault leaves it armed
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         parity_enable <= 1'b0;
      else if (wr && hit(`SFESM_CMD_MEM_CTRL))
         parity_enable <= cmd.cmd_wdata[`SFESM_BIT_PARITY_EN];
   end

   // ------------------------------------------------------------
   // safe mode
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         mode <= sfesm_pkg::SFESM_RUN;
      else
      begin
         unique case (mode)
            sfesm_pkg::SFESM_RUN:
               if (fault_hit)
                  mode <= sfesm_pkg::SFESM_SAFE;
            sfesm_pkg::SFESM_SAFE:
               if (wr && hit(`SFESM_CMD_MEM_CTRL) &&
                  cmd.cmd_wdata[`SFESM_BIT_RUN_EN])
                  mode <= sfesm_pkg::SFESM_RUN;
            default:
               mode <= sfesm_pkg::SFESM_SAFE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         safe_mode <= 1'b0;
      else
         safe_mode <= (mode == sfesm_pkg::SFESM_SAFE) || fault_hit;
   end

   // ------------------------------------------------------------
   // fast shutdown match
   // ------------------------------------------------------------
   logic [1:0] group_hit;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : grp
         logic [3:0] m;
         genvar c;
         for (c = 0; c < 4; c++)
         begin : ch
            assign m[c] = prio_mode ?
               (shutdown_code_valid &&
                shutdown_code >= prio_level[(g*4+c)*3 +: 3]) :
               (fast_shutdown_input && fast_shutdown_enable[g*4+c]);
         end
         assign group_hit[g] = |m;
      end
   endgenerate

   // ------------------------------------------------------------
   // event register
   // ------------------------------------------------------------
   logic [7:0] ev_set;
   logic clear_read;
   logic [3:0] events_hi;
   logic [3:0] events_lo;
   assign events = {events_hi, events_lo};
   always_comb
   begin
      ev_set = 8'h00;
      ev_set[`SFESM_BIT_THERMAL] = cond.thermal_shutdown;
      ev_set[`SFESM_BIT_LOCKOUT] = cond.logic_supply_lockout;
      ev_set[`SFESM_BIT_WARNING] = cond.logic_supply_warning;
      ev_set[`SFESM_BIT_PORT_LOW] = cond.port_supply_low;
      ev_set[`SFESM_BIT_SHUTDOWN] = |group_hit;
      ev_set[`SFESM_BIT_MEMFAULT] = fault_hit;
      // lockout kept while port supply low
      if (cond.port_supply_low)
         ev_set[`SFESM_BIT_LOCKOUT] = ev_set[`SFESM_BIT_LOCKOUT] |
            events[`SFESM_BIT_LOCKOUT];
   end

   assign clear_read = rd && hit(`SFESM_CMD_EVENTS_CR);

   // upper flags only see power-on; the pin reset is taken synchronously
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         events_hi <= EVENTS_POR[7:4];
      else if (clear_read)
         events_hi <= ev_set[7:4];
      else
         events_hi <= events_hi | ev_set[7:4];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         events_lo <= 4'h0;
      else if (!reset_pin_n)
         events_lo <= 4'h0;
      else if (clear_read)
         events_lo <= ev_set[3:0] & LIVE_MASK[3:0];
      else
         events_lo <= (events_lo | ev_set[3:0]) & LIVE_MASK[3:0];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         event_irq <= 1'b0;
      else if (clear_read)
         event_irq <= |ev_set;
      else
         event_irq <= |(events | ev_set);
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         read_data <= 8'h00;
         read_valid <= 1'b0;
      end
      else
      begin
         read_valid <= rd;
         if (rd)
         begin
            unique case (cmd.cmd_addr)
               `SFESM_CMD_EVENTS_RO, `SFESM_CMD_EVENTS_CR:
                  read_data <= events;
               `SFESM_CMD_DISC_ONE:
                  read_data <= channel_one_result;
               `SFESM_CMD_DISC_TWO:
                  read_data <= channel_two_result;
               `SFESM_CMD_PRIO_MODE:
                  read_data <= {7'h00, prio_mode};
               `SFESM_CMD_FW_REV:
                  read_data <= (mode == sfesm_pkg::SFESM_SAFE) ?
                     `SFESM_SAFE_MARKER : firmware_revision;
               `SFESM_CMD_MEM_CTRL:
                  read_data <= {6'h00, parity_enable, run_enable};
               default:
                  read_data <= 8'h00;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // channel control
   // ------------------------------------------------------------
   logic [CHANNELS-1:0] next_enable;
   logic [CHANNELS-1:0] shut_mask;
   logic power_blocked;
   always_comb
   begin
      shut_mask = {{4{group_hit[1]}}, {4{group_hit[0]}}};
      power_blocked = events[`SFESM_BIT_PORT_LOW] && !cond.port_supply_ok;
      next_enable = channel_enable & ~shut_mask;
      // powered channels stay in safe mode
      if (!power_blocked && cond.thermal_cool &&
         mode == sfesm_pkg::SFESM_RUN && !fault_hit)
         next_enable = next_enable | channel_power_on_command;
      if (cond.thermal_shutdown)
         next_enable = '0;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         channel_enable <= '0;
      else
         channel_enable <= next_enable;
   end

   // unpowered channels off in safe mode
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         channel_force_off <= '0;
      else if (cond.thermal_shutdown)
         channel_force_off <= '1;
      else if (mode == sfesm_pkg::SFESM_SAFE || fault_hit)
         channel_force_off <= ~channel_powered;
      else
         channel_force_off <= '0;
   end

   // keep detect events unless supply dead
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         events_keep <= 1'b1;
      else
         events_keep <= !cond.port_supply_dead;
   end
endmodule // sfesm_block

// ===== sfesm_host.sv
/*
 host model: sends one-cycle register commands at the falling edge.
 assumes the bench calls send and samples read data when it returns.
*/
`timescale 1ns/1ps
`include "sfesm_map.svh"
module sfesm_host (
   input wire logic sys_clk,
   input wire logic safe_mode,
   output sfesm_pkg::sfesm_cmd_t cmd
);
   initial cmd = '0;
   task automatic send(input logic w, input logic [7:0] a, d);
      if (safe_mode && a != `SFESM_CMD_MEM_CTRL &&
          a != `SFESM_CMD_FW_REV && a[7:1] != 7'h05)
         return;
      @(negedge sys_clk);
      cmd <= '{1'b1, w, a, d};
      @(negedge sys_clk);
      cmd <= '0;
   endtask
endmodule // sfesm_host

// ===== sfesm_block_sva.sv
/*
 checker of the supply_fault_events block.
 assumes the map header and type package are compiled first.
*/
`timescale 1ns/1ps
`include "sfesm_map.svh"
module sfesm_sva #(
   parameter int CHANNELS = 8
)(
   input wire logic sys_clk,
   input wire logic rst,
   input wire sfesm_pkg::sfesm_cmd_t cmd,
   input wire sfesm_pkg::sfesm_cond_t cond,
   input wire logic fast_shutdown_input,
   input wire logic shutdown_code_valid,
   input wire logic [7:0] channel_one_result,
   input wire logic [7:0] read_data,
   input wire logic read_valid,
   input wire logic event_irq,
   input wire logic [CHANNELS-1:0] channel_enable,
   input wire logic events_keep,
   input wire logic safe_mode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic rd;
   logic quiet;
   logic run_wr;
   assign rd = cmd.cmd_valid && !cmd.cmd_write;
   // only event sources count; cool and ok levels set nothing
   assign quiet = (cond & 8'hB9) == 8'h00 && !fast_shutdown_input &&
      !shutdown_code_valid;
   assign run_wr = cmd.cmd_valid && cmd.cmd_write &&
      cmd.cmd_addr == `SFESM_CMD_MEM_CTRL &&
      cmd.cmd_wdata[`SFESM_BIT_RUN_EN];
   property p_answer; rd |=> read_valid; endproperty
   a_answer: assert property (p_answer)
      else $error("read got no answer");
   property p_rsvd; rd && cmd.cmd_addr[7:1] == 7'h05 |=> !read_data[3:2];
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved event bits not zero");
   property p_disc; rd && cmd.cmd_addr == `SFESM_CMD_DISC_ONE |=>
      read_data == $past(channel_one_result); endproperty
   a_disc: assert property (p_disc)
      else $error("discovery byte wrong");
   property p_marker; rd && safe_mode && cmd.cmd_addr == `SFESM_CMD_FW_REV
      |=> read_data == `SFESM_SAFE_MARKER; endproperty
   a_marker: assert property (p_marker)
      else $error("safe marker missing");
   property p_hot; cond.thermal_shutdown |=> channel_enable == '0;
   endproperty
   a_hot: assert property (p_hot)
      else $error("channel on during thermal shutdown");
   property p_dead; cond.port_supply_dead |=> !events_keep; endproperty
   a_dead: assert property (p_dead)
      else $error("events kept below lockout");
   // the flag lags the mode by one edge after the releasing write
   property p_stay; safe_mode && !run_wr && !$past(run_wr) |=> safe_mode;
   endproperty
   a_stay: assert property (p_stay)
      else $error("safe mode left early");
   property p_release; rd && cmd.cmd_addr == `SFESM_CMD_EVENTS_CR && quiet
      |=> !event_irq; endproperty
   a_release: assert property (p_release)
      else $error("interrupt held after clearing read");
   property p_nopower; (cond.port_supply_low && !cond.port_supply_ok)[*2]
      |=> (channel_enable & ~$past(channel_enable)) == '0; endproperty
   a_nopower: assert property (p_nopower)
      else $error("channel powered on while supply low");
endmodule // sfesm_sva

bind sfesm_block sfesm_sva #(.CHANNELS(CHANNELS)) chk_u (
   .sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cond(cond),
   .fast_shutdown_input(fast_shutdown_input),
   .shutdown_code_valid(shutdown_code_valid),
   .channel_one_result(channel_one_result), .read_data(read_data),
   .read_valid(read_valid), .event_irq(event_irq),
   .channel_enable(channel_enable), .events_keep(events_keep),
   .safe_mode(safe_mode));

// ===== sfesm_block_tb_top.sv
/*
 self-checking bench of the supply_fault_events block.
 assumes the host model, checker and design are compiled before it.
*/
`timescale 1ns/1ps
`include "sfesm_map.svh"
module sfesm_block_tb_top;
   logic sys_clk = 0;
   logic rst = 1;
   logic reset_pin_n = 1;
   sfesm_pkg::sfesm_cmd_t cmd;
   sfesm_pkg::sfesm_cond_t cond = '0;
   logic fsi = 0;
   logic code_v = 0;
   logic par = 0;
   logic [2:0] code = '0;
   logic [7:0] fs_en = 0, pwd = 0, pon = 0, r1 = 0, r2 = 0;
   logic [7:0] rdata, ena, foff;
   logic rvalid, irq, keep, safe;
   logic [7:0] lf = 8'h39;
   // revision seen in run mode: the value is arbitrary
   localparam logic [7:0] FW_REV_ANY = 8'h21;
   int mismatches = 0;
   int tests_run = 0;
   initial forever #4 sys_clk = ~sys_clk;
   sfesm_host host_u (.sys_clk(sys_clk), .safe_mode(safe), .cmd(cmd));
   sfesm_block #(.CHANNELS(8)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n), .cmd(cmd),
      .cond(cond), .fast_shutdown_input(fsi), .shutdown_code(code),
      .shutdown_code_valid(code_v), .fast_shutdown_enable(fs_en),
      .channel_powered(pwd), .channel_power_on_command(pon),
      .channel_one_result(r1), .channel_two_result(r2),
      .parity_image_loaded(par), .firmware_revision(FW_REV_ANY),
      .read_data(rdata), .read_valid(rvalid), .event_irq(irq),
      .channel_enable(ena), .channel_force_off(foff),
      .events_keep(keep), .safe_mode(safe));
   // ----------------------------------------
   // expectations and bus helpers
   // ----------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // the reset pin spares only the supply and thermal flags
   function automatic logic [7:0] pinned(input logic [7:0] v);
      return v & 8'hF0;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host_u.send(1'b0, a, 8'h00);
      chk(rdata, exp);
   endtask
   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wait_safe(input logic v);
      int n;
      n = 0;
      while (safe !== v && n < 20)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk({7'h00, safe}, {7'h00, v});
      if (n == 20)
         finish_test();
   endtask
   initial
   begin
      #400000;
      mismatches++;
      finish_test();
   end
   initial
   begin
      hold(12);
      rst = 0;
      rd(`SFESM_CMD_EVENTS_RO, `SFESM_EVENTS_POR);
      for (int i = 0; i < 4; i++)
      begin
         lf = lfsr(lf);
         r1 = lf;
         r2 = ~lf;
         rd(`SFESM_CMD_DISC_ONE, lf);
         rd(`SFESM_CMD_DISC_TWO, ~lf);
      end
      rd(8'h0E, 8'h00);
      rd(`SFESM_CMD_FW_REV, FW_REV_ANY);
      cond.port_supply_low = 1;
      rd(`SFESM_CMD_EVENTS_CR, 8'h70);
      rd(`SFESM_CMD_EVENTS_RO, 8'h50);
      pon = 8'hFF;
      cond.thermal_cool = 1;
      hold(4);
      chk(ena, 8'h00);
      cond.port_supply_dead = 1;
      hold(2);
      chk({7'h00, keep}, 8'h00);
      cond = '{thermal_cool: 1, port_supply_ok: 1, default: 0};
      hold(4);
      chk(ena, 8'hFF);
      rd(`SFESM_CMD_EVENTS_CR, 8'h50);
      chk({7'h00, irq}, 8'h00);
      rd(`SFESM_CMD_EVENTS_RO, 8'h00);
      cond.logic_supply_lockout = 1;
      cond.logic_supply_warning = 1;
      hold(1);
      cond.logic_supply_lockout = 0;
      cond.logic_supply_warning = 0;
      rd(`SFESM_CMD_EVENTS_CR, 8'h60);
      rd(`SFESM_CMD_EVENTS_RO, 8'h00);
      cond.thermal_shutdown = 1;
      hold(2);
      chk(ena, 8'h00);
      cond.thermal_shutdown = 0;
      hold(4);
      chk(ena, 8'hFF);
      host_u.send(1'b1, `SFESM_CMD_PRIO_MODE, 8'h00);
      fs_en = 8'h10;
      fsi = 1;
      hold(2);
      fsi = 0;
      rd(`SFESM_CMD_EVENTS_RO, 8'h82);
      reset_pin_n = 0;
      hold(2);
      reset_pin_n = 1;
      rd(`SFESM_CMD_EVENTS_CR, pinned(8'h82));
      fs_en = 8'hFF;
      host_u.send(1'b1, `SFESM_CMD_PRIO_MODE, 8'h01);
      host_u.send(1'b1, `SFESM_CMD_PRIO_LOW, 8'h33);
      host_u.send(1'b1, `SFESM_CMD_PRIO_HIGH, 8'h77);
      for (int c = 0; c < 8; c++)
      begin
         code = c[2:0];
         code_v = 1;
         hold(2);
         code_v = 0;
         rd(`SFESM_CMD_EVENTS_CR, {6'h00, c >= 3, 1'b0});
      end
      lf = lfsr(lf);
      pwd = lf;
      host_u.send(1'b1, `SFESM_CMD_MEM_CTRL, 8'h03);
      par = 1;
      cond.memory_error = 1;
      hold(1);
      cond.memory_error = 0;
      wait_safe(1'b1);
      hold(2);
      chk(foff, ~pwd);
      rd(`SFESM_CMD_FW_REV, `SFESM_SAFE_MARKER);
      rd(`SFESM_CMD_MEM_CTRL, 8'h02);
      rd(`SFESM_CMD_EVENTS_RO, 8'h01);
      host_u.send(1'b1, `SFESM_CMD_MEM_CTRL, 8'h03);
      wait_safe(1'b0);
      rd(`SFESM_CMD_EVENTS_RO, 8'h01);
      rst = 1;
      hold(2);
      rst = 0;
      rd(`SFESM_CMD_EVENTS_RO, `SFESM_EVENTS_POR);
      finish_test();
   end
endmodule // sfesm_block_tb_top
